// File: rtl/cirs_pkg.sv
// Purpose: constants for the interrupt, trap, wait and restart sequencer
// Assumes: 8-bit data, 16-bit addresses, vectors at the top of memory
// Notes: one machine cycle is one phase-one plus one phase-two strobe pair
package cirs_pkg;
  // ----------------------------------------------------------------
  // Vectors (lower address holds the high byte)
  // ----------------------------------------------------------------
  localparam logic [15:0] VEC_RESTART = 16'hFFFE;
  localparam logic [15:0] VEC_NMI = 16'hFFFC;
  localparam logic [15:0] VEC_TRAP = 16'hFFFA;
  localparam logic [15:0] VEC_IRQ = 16'hFFF8;
  // ----------------------------------------------------------------
  // Condition codes, register reset values and stacked byte count
  // ----------------------------------------------------------------
  localparam int MASK_BIT = 4;
  localparam logic [7:0] CC_RESET = 8'h10;
  localparam logic [15:0] SP_RESET = 16'h0000;
  localparam int STACK_BYTES = 7;
  // ----------------------------------------------------------------
  // Sequencer states and request sources
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_RUN = 3'b000,
    ST_STACK = 3'b001,
    ST_VEC_HI = 3'b010,
    ST_VEC_LO = 3'b011,
    ST_WAIT = 3'b100,
    ST_IDLE = 3'b101
  } cirs_state_t;
  typedef enum logic [1:0] {
    SRC_NMI = 2'b00,
    SRC_IRQ = 2'b01,
    SRC_TRAP = 2'b10,
    SRC_WAIT = 2'b11
  } cirs_src_t;
endpackage

// File: rtl/cirs_sequencer.sv
// Purpose: interrupt, trap, wait and restart sequencing of an 8-bit CPU
// Assumes: PHI1/PHI2 are single-cycle strobes from a phase generator on
//   CLOCK; the core pulses INSTR_DONE in the last cycle of an instruction
// Notes: one bus byte per machine cycle; address is presented on the
//   phase-one strobe and data is captured on the phase-two strobe
`timescale 1ns/100ps

module cirs_sequencer
  import cirs_pkg::*;
(
  input wire logic CLOCK,
  input wire logic SYS_RST,
  input wire logic PHI1,
  input wire logic PHI2,
  input wire logic RESET_N,
  input wire logic NMI_N,
  input wire logic IRQ_N,
  input wire logic HALT_N,
  input wire logic INSTR_DONE,
  input wire logic TRAP_EXEC,
  input wire logic WAIT_EXEC,
  input wire logic CC_WR,
  input wire logic [7:0] CC_WDATA,
  input wire logic [15:0] PC_IN,
  input wire logic [15:0] X_IN,
  input wire logic [7:0] A_IN,
  input wire logic [7:0] B_IN,
  input wire logic [15:0] SP_IN,
  input wire logic [7:0] DATA_IN,
  output logic [15:0] ADDR,
  output logic [7:0] DATA_OUT,
  output logic DATA_OE,
  output logic RW,
  output logic VMA,
  output logic BUSY,
  output logic HALTED,
  output logic CLEAR_REGS,
  output logic PC_LOAD,
  output logic [15:0] PC_OUT,
  output logic [15:0] SP_OUT,
  output logic [7:0] CC_OUT
);
  // ----------------------------------------------------------------
  // Pin synchronisers: three flops, change counts when 2nd and 3rd agree
  // ----------------------------------------------------------------
  logic [2:0] rst_s_q, nmi_s_q, irq_s_q, halt_s_q;
  logic rst_f_q, nmi_f_q, irq_f_q, halt_f_q;
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      rst_s_q <= 3'h0;
      nmi_s_q <= 3'h7;
      irq_s_q <= 3'h7;
      halt_s_q <= 3'h7;
      rst_f_q <= 1'b0;
      nmi_f_q <= 1'b1;
      irq_f_q <= 1'b1;
      halt_f_q <= 1'b1;
    end else begin
      rst_s_q <= {rst_s_q[1:0], RESET_N};
      nmi_s_q <= {nmi_s_q[1:0], NMI_N};
      irq_s_q <= {irq_s_q[1:0], IRQ_N};
      halt_s_q <= {halt_s_q[1:0], HALT_N};
      if (rst_s_q[1] == rst_s_q[2]) rst_f_q <= rst_s_q[2];
      if (nmi_s_q[1] == nmi_s_q[2]) nmi_f_q <= nmi_s_q[2];
      if (irq_s_q[1] == irq_s_q[2]) irq_f_q <= irq_s_q[2];
      if (halt_s_q[1] == halt_s_q[2]) halt_f_q <= halt_s_q[2];
    end
  end
  wire rst_clean = (rst_s_q[1] == rst_s_q[2]) ? rst_s_q[2] : rst_f_q;
  wire nmi_clean = (nmi_s_q[1] == nmi_s_q[2]) ? nmi_s_q[2] : nmi_f_q;
  wire irq_clean = (irq_s_q[1] == irq_s_q[2]) ? irq_s_q[2] : irq_f_q;
  wire halt_clean = (halt_s_q[1] == halt_s_q[2]) ? halt_s_q[2] : halt_f_q;
  // Reset pin low holds the restart pending; its rising edge starts it
  wire rst_rise = rst_clean & ~rst_f_q;
  wire nmi_fall = ~nmi_clean & nmi_f_q;
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  cirs_state_t state_q, state_d;
  cirs_src_t src_q, src_d;
  logic nmi_pend_q, nmi_pend_d;
  logic irq_lvl_q, irq_lvl_d;
  logic restart_q, restart_d;
  logic [2:0] idx_q, idx_d;
  logic [15:0] sp_q, sp_d;
  logic [7:0] cc_q, cc_d;
  logic [7:0] vhi_q, vhi_d;
  logic [15:0] pc_q, pc_d;
  logic [15:0] vec_q, vec_d;
  logic [7:0] dout_q, dout_d;
  logic pcl_q, pcl_d;
  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire mask = cc_q[MASK_BIT];
  wire hw_ok = halt_clean;
  wire irq_take = irq_lvl_q & ~mask & hw_ok;
  wire nmi_take = nmi_pend_q & hw_ok;
  wire at_end = INSTR_DONE & PHI1;
  wire in_reset = ~rst_clean;
  logic [7:0] push_byte;
  always_comb begin
    case (idx_q)
      3'd0: push_byte = PC_IN[7:0];
      3'd1: push_byte = PC_IN[15:8];
      3'd2: push_byte = X_IN[7:0];
      3'd3: push_byte = X_IN[15:8];
      3'd4: push_byte = B_IN;
      3'd5: push_byte = A_IN;
      default: push_byte = cc_q;
    endcase
  end
  wire [15:0] vec_addr = (state_q == ST_VEC_LO) ? (vec_q | 16'h0001)
                                                 : vec_q;
  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    src_d = src_q;
    idx_d = idx_q;
    sp_d = sp_q;
    cc_d = CC_WR ? CC_WDATA : cc_q;
    vhi_d = vhi_q;
    pc_d = pc_q;
    vec_d = vec_q;
    dout_d = dout_q;
    pcl_d = 1'b0;
    restart_d = restart_q;
    // Edge flag: a new edge wins over the clear on acceptance
    nmi_pend_d = nmi_fall | nmi_pend_q;
    if (PHI2) irq_lvl_d = ~irq_clean;
    else irq_lvl_d = irq_lvl_q;
    if (in_reset) begin
      state_d = ST_IDLE;
      sp_d = SP_RESET;
      cc_d = CC_RESET;
      nmi_pend_d = 1'b0;
      restart_d = 1'b1;
    end else if (rst_rise || (restart_q && state_q == ST_IDLE)) begin
      if (PHI1) begin
        state_d = ST_VEC_HI;
        vec_d = VEC_RESTART;
        restart_d = 1'b0;
      end
    end else begin
      case (state_q)
        ST_RUN: begin
          if (at_end && nmi_take) begin
            state_d = ST_STACK;
            src_d = SRC_NMI;
            nmi_pend_d = nmi_fall;
            idx_d = 3'd0;
            sp_d = SP_IN;
          end else if (at_end && irq_take) begin
            state_d = ST_STACK;
            src_d = SRC_IRQ;
            idx_d = 3'd0;
            sp_d = SP_IN;
          end else if (at_end && TRAP_EXEC) begin
            state_d = ST_STACK;
            src_d = SRC_TRAP;
            idx_d = 3'd0;
            sp_d = SP_IN;
          end else if (at_end && WAIT_EXEC) begin
            state_d = ST_STACK;
            src_d = SRC_WAIT;
            idx_d = 3'd0;
            sp_d = SP_IN;
          end
        end
        ST_STACK: begin
          if (!PHI2) dout_d = push_byte;
          if (PHI2) begin
            sp_d = sp_q - 16'h0001;
            idx_d = idx_q + 3'd1;
            if (idx_q == 3'(STACK_BYTES - 1)) begin
              if (src_q == SRC_WAIT) begin
                state_d = ST_WAIT;
              end else begin
                cc_d[MASK_BIT] = 1'b1;
                state_d = ST_VEC_HI;
                vec_d = (src_q == SRC_NMI) ? VEC_NMI :
                        (src_q == SRC_IRQ) ? VEC_IRQ : VEC_TRAP;
              end
            end
          end
        end
        ST_WAIT: begin
          if (nmi_take) begin
            nmi_pend_d = nmi_fall;
            cc_d[MASK_BIT] = 1'b1;
            vec_d = VEC_NMI;
            state_d = ST_VEC_HI;
          end else if (irq_take) begin
            cc_d[MASK_BIT] = 1'b1;
            vec_d = VEC_IRQ;
            state_d = ST_VEC_HI;
          end
        end
        ST_VEC_HI: begin
          if (PHI2) begin
            vhi_d = DATA_IN;
            state_d = ST_VEC_LO;
          end
        end
        ST_VEC_LO: begin
          if (PHI2) begin
            pc_d = {vhi_q, DATA_IN};
            pcl_d = 1'b1;
            state_d = ST_RUN;
          end
        end
        default: state_d = ST_RUN;
      endcase
    end
  end
  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state_q <= ST_IDLE;
      src_q <= SRC_NMI;
      nmi_pend_q <= 1'b0;
      irq_lvl_q <= 1'b0;
      restart_q <= 1'b1;
      idx_q <= 3'h0;
      sp_q <= SP_RESET;
      cc_q <= CC_RESET;
      vhi_q <= 8'h00;
      pc_q <= 16'h0000;
      vec_q <= VEC_RESTART;
      dout_q <= 8'h00;
      pcl_q <= 1'b0;
    end else begin
      state_q <= state_d;
      src_q <= src_d;
      nmi_pend_q <= nmi_pend_d;
      irq_lvl_q <= irq_lvl_d;
      restart_q <= restart_d;
      idx_q <= idx_d;
      sp_q <= sp_d;
      cc_q <= cc_d;
      vhi_q <= vhi_d;
      pc_q <= pc_d;
      vec_q <= vec_d;
      dout_q <= dout_d;
      pcl_q <= pcl_d;
    end
  end
  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  wire stacking = (state_q == ST_STACK);
  wire vectoring = (state_q == ST_VEC_HI) || (state_q == ST_VEC_LO);
  // Vector addresses already carry all-ones in the upper byte
  assign ADDR = stacking ? sp_q :
                (vectoring ? vec_addr : 16'hFF00);
  assign DATA_OUT = dout_q;
  assign DATA_OE = stacking;
  assign RW = ~stacking;
  assign VMA = stacking | vectoring;
  assign BUSY = (state_q != ST_RUN);
  assign HALTED = (state_q == ST_WAIT);
  assign CLEAR_REGS = in_reset | (state_q == ST_IDLE);
  assign PC_LOAD = pcl_q;
  assign PC_OUT = pc_q;
  assign SP_OUT = sp_q;
  assign CC_OUT = cc_q;
endmodule // cirs_sequencer

// File: verification/cirs_checker.sv
// Purpose: port-level checks on the sequencer
// Assumes: phase strobes repeat every four clocks
// Notes: bound to every sequencer instance
`timescale 1ns/100ps
module cirs_checker
  import cirs_pkg::*;
(
  input wire logic CLOCK,
  input wire logic SYS_RST,
  input wire logic PHI1,
  input wire logic PHI2,
  input wire logic HALT_N,
  input wire logic INSTR_DONE,
  input wire logic TRAP_EXEC,
  input wire logic WAIT_EXEC,
  input wire logic [15:0] ADDR,
  input wire logic DATA_OE,
  input wire logic RW,
  input wire logic VMA,
  input wire logic BUSY,
  input wire logic HALTED,
  input wire logic PC_LOAD,
  input wire logic [15:0] SP_OUT,
  input wire logic [7:0] CC_OUT
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  logic [3:0] push_q;
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);
  // Counts bytes of one stacking run; cleared while not stacking
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) push_q <= 4'h0;
    else if (!DATA_OE) push_q <= 4'h0;
    else if (PHI2) push_q <= push_q + 4'h1;
  end
  sequence vec_hi;
    VMA && RW && PHI2 && ADDR >= 16'hFFF8 && !ADDR[0];
  endsequence
  sequence vec_lo;
    VMA && RW && PHI2 && ADDR >= 16'hFFF8 && ADDR[0];
  endsequence
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  chk_push_strobe: assert property (DATA_OE |-> VMA && !RW)
    else $error("push without write strobe");
  chk_high_ones: assert property (!DATA_OE |-> ADDR[15:8] == 8'hFF)
    else $error("high address not all ones");
  chk_mask_load: assert property (PC_LOAD |-> CC_OUT[MASK_BIT])
    else $error("vector loaded with mask clear");
  chk_load_pulse: assert property (PC_LOAD |=> !PC_LOAD)
    else $error("load pulse too long");
  chk_vec_order: assert property (vec_hi |-> ##4 (vec_lo
    and ADDR[15:1] == $past(ADDR[15:1], 4)) ##[1:4] PC_LOAD)
    else $error("vector pair out of order");
  chk_sp_step: assert property (DATA_OE && PHI2
    |=> SP_OUT == $past(SP_OUT) - 16'h0001)
    else $error("stack pointer did not step down");
  chk_push_count: assert property ($fell(DATA_OE) |-> push_q == 4'h7)
    else $error("wrong number of pushed bytes");
  chk_wait_quiet: assert property (HALTED |-> !VMA && !DATA_OE)
    else $error("bus active while waiting");
  chk_halt_block: assert property ((!HALT_N) [*6] ##1 (!HALT_N && PHI1
    && INSTR_DONE && !TRAP_EXEC && !WAIT_EXEC && !BUSY) |=> !BUSY)
    else $error("interrupt taken while halted");
endmodule // cirs_checker

bind cirs_sequencer cirs_checker u_chk (.CLOCK(CLOCK), .SYS_RST(SYS_RST),
  .PHI1(PHI1), .PHI2(PHI2), .HALT_N(HALT_N), .INSTR_DONE(INSTR_DONE),
  .TRAP_EXEC(TRAP_EXEC), .WAIT_EXEC(WAIT_EXEC), .ADDR(ADDR),
  .DATA_OE(DATA_OE), .RW(RW), .VMA(VMA), .BUSY(BUSY), .HALTED(HALTED),
  .PC_LOAD(PC_LOAD), .SP_OUT(SP_OUT), .CC_OUT(CC_OUT));

// File: verification/cirs_mem.sv
// Purpose: program memory holding the vector table
// Assumes: read when VMA is high and RW is high
// Notes: released bus shows a changing pattern
`timescale 1ns/100ps
module cirs_mem (
  input wire logic CLOCK,
  input wire logic [15:0] ADDR,
  input wire logic VMA,
  input wire logic RW,
  output logic [7:0] DATA_IN
);
  logic [7:0] junk_q = 8'h3C;
  // Stale data must never pass for a real vector byte
  always_ff @(posedge CLOCK) junk_q <= ~junk_q + 8'h01;
  assign DATA_IN = (VMA && RW) ? (ADDR[7:0] ^ 8'hA5) : junk_q;
endmodule // cirs_mem

// File: verification/cirs_sequencer_tb.sv
// Purpose: self-checking bench for the sequencer
// Assumes: vector byte at address a is a[7:0] xor A5
// Notes: phase strobes every four clocks
`timescale 1ns/100ps
module cirs_sequencer_tb;
  import cirs_pkg::*;
  logic CLOCK = 1'b0, SYS_RST = 1'b1, RESET_N = 1'b0, NMI_N = 1'b1;
  logic IRQ_N = 1'b1, HALT_N = 1'b1, INSTR_DONE = 1'b0, TRAP_EXEC = 1'b0;
  logic WAIT_EXEC = 1'b0, CC_WR = 1'b0, PHI1, PHI2;
  logic DATA_OE, RW, VMA, BUSY, HALTED, CLEAR_REGS, PC_LOAD;
  logic [7:0] CC_WDATA = 8'h00, A_IN = 8'h00, B_IN = 8'h00;
  logic [7:0] DATA_IN, DATA_OUT, CC_OUT;
  logic [15:0] PC_IN = 16'h0000, X_IN = 16'h0000, SP_IN = 16'h0000;
  logic [15:0] ADDR, PC_OUT, SP_OUT, pc_got;
  logic [1:0] ph = 2'h0;
  logic [7:0] got[$];
  logic [15:0] sa[$];
  int exp[$];
  int n_mismatch = 0, compares = 0, loads = 0, seed, cc;
  always #10 CLOCK = ~CLOCK;
  always @(posedge CLOCK) ph <= ph + 2'h1;
  assign PHI1 = (ph == 2'h0);
  assign PHI2 = (ph == 2'h2);
  always @(posedge CLOCK) begin
    if (DATA_OE === 1'b1 && PHI2) begin
      got.push_back(DATA_OUT);
      sa.push_back(ADDR);
    end
    if (PC_LOAD === 1'b1) begin
      pc_got = PC_OUT;
      loads++;
    end
  end
  cirs_sequencer DUT (.CLOCK(CLOCK), .SYS_RST(SYS_RST), .PHI1(PHI1),
    .PHI2(PHI2), .RESET_N(RESET_N), .NMI_N(NMI_N), .IRQ_N(IRQ_N),
    .HALT_N(HALT_N), .INSTR_DONE(INSTR_DONE), .TRAP_EXEC(TRAP_EXEC),
    .WAIT_EXEC(WAIT_EXEC), .CC_WR(CC_WR), .CC_WDATA(CC_WDATA),
    .PC_IN(PC_IN), .X_IN(X_IN), .A_IN(A_IN), .B_IN(B_IN), .SP_IN(SP_IN),
    .DATA_IN(DATA_IN), .ADDR(ADDR), .DATA_OUT(DATA_OUT),
    .DATA_OE(DATA_OE), .RW(RW), .VMA(VMA), .BUSY(BUSY), .HALTED(HALTED),
    .CLEAR_REGS(CLEAR_REGS), .PC_LOAD(PC_LOAD), .PC_OUT(PC_OUT),
    .SP_OUT(SP_OUT), .CC_OUT(CC_OUT));
  cirs_mem u_mem (.CLOCK(CLOCK), .ADDR(ADDR), .VMA(VMA), .RW(RW),
    .DATA_IN(DATA_IN));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task summarize;
    $display("compares=%0d mismatches=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task chk(input logic [15:0] g, input logic [15:0] e);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  function automatic logic [15:0] vexp(input logic [15:0] v);
    return {v[7:0] ^ 8'hA5, v[7:0] ^ 8'hA4};
  endfunction
  task wt(input int l0);
    for (int i = 0; i < 400; i++) begin
      if (loads != l0) return;
      @(posedge CLOCK);
    end
    n_mismatch++;
    summarize();
  endtask
  task boundary(input logic t, input logic w);
    for (int i = 0; i < 8; i++) begin
      @(posedge CLOCK);
      if (ph == 2'h3) break;
    end
    INSTR_DONE <= 1'b1;
    TRAP_EXEC <= t;
    WAIT_EXEC <= w;
    @(posedge CLOCK);
    INSTR_DONE <= 1'b0;
    TRAP_EXEC <= 1'b0;
    WAIT_EXEC <= 1'b0;
  endtask
  task setcc(input logic [7:0] d);
    @(posedge CLOCK);
    CC_WR <= 1'b1;
    CC_WDATA <= d;
    @(posedge CLOCK);
    CC_WR <= 1'b0;
    cc = d;
  endtask
  task restart;
    int l0;
    l0 = loads;
    RESET_N <= 1'b0;
    repeat (10) @(posedge CLOCK);
    chk({15'h0, CLEAR_REGS}, 16'h0001);
    got.delete();
    RESET_N <= 1'b1;
    wt(l0);
    chk(pc_got, vexp(VEC_RESTART));
    chk({8'h00, CC_OUT}, 16'h0010);
    chk(16'(got.size()), 16'h0000);
    cc = 8'h10;
  endtask
  task serve(input logic t, input logic w, input logic [15:0] v);
    int l0, r1, r2;
    l0 = loads;
    r1 = $random(seed);
    r2 = $random(seed);
    PC_IN <= r1[15:0];
    X_IN <= r1[31:16];
    A_IN <= r2[7:0];
    B_IN <= r2[15:8];
    SP_IN <= r2[31:16];
    exp = '{r1[7:0], r1[15:8], r1[23:16], r1[31:24], r2[15:8], r2[7:0], cc};
    got.delete();
    sa.delete();
    boundary(t, w);
    if (w) begin
      for (int i = 0; i < 400 && HALTED !== 1'b1; i++) @(posedge CLOCK);
      chk({15'h0, HALTED}, 16'h0001);
      if (v == VEC_NMI) NMI_N <= 1'b0;
      else IRQ_N <= 1'b0;
    end
    wt(l0);
    chk(16'(got.size()), 16'h0007);
    if (got.size() == 7)
      for (int i = 0; i < 7; i++) chk({8'h00, got[i]}, 16'(exp[i]));
    if (sa.size() == 7)
      for (int i = 0; i < 7; i++) chk(sa[i], r2[31:16] - 16'(i));
    chk(pc_got, vexp(v));
    chk({15'h0, CC_OUT[MASK_BIT]}, 16'h0001);
    cc = cc | 8'h10;
    NMI_N <= 1'b1;
    IRQ_N <= 1'b1;
    // Let the released request lines pass the synchroniser and a PHI2
    repeat (8) @(posedge CLOCK);
  endtask
  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    seed = 71;
    repeat (3) @(posedge CLOCK);
    SYS_RST <= 1'b0;
    restart();
    IRQ_N <= 1'b0;
    repeat (8) @(posedge CLOCK);
    boundary(1'b0, 1'b0);
    repeat (8) @(posedge CLOCK);
    chk({15'h0, BUSY}, 16'h0000);
    IRQ_N <= 1'b1;
    setcc(8'($random(seed)) & 8'hEF);
    HALT_N <= 1'b0;
    IRQ_N <= 1'b0;
    repeat (8) @(posedge CLOCK);
    boundary(1'b0, 1'b0);
    repeat (8) @(posedge CLOCK);
    chk({15'h0, BUSY}, 16'h0000);
    HALT_N <= 1'b1;
    repeat (8) @(posedge CLOCK);
    serve(1'b0, 1'b0, VEC_IRQ);
    serve(1'b1, 1'b0, VEC_TRAP);
    NMI_N <= 1'b0;
    repeat (8) @(posedge CLOCK);
    serve(1'b0, 1'b0, VEC_NMI);
    for (int k = 0; k < 2; k++) begin
      setcc(8'($random(seed)) & 8'hEF);
      serve(1'b0, 1'b1, k ? VEC_NMI : VEC_IRQ);
    end
    restart();
    summarize();
  end
endmodule // cirs_sequencer_tb
